// [design/sisc_pkg.sv]
// Purpose: Constants for the interrupt source status and data event config block
// Assumes: Byte-wide register port behind the serial interface core
// Notes:   Offsets are register addresses on the device's serial interface
package sisc_pkg;
	localparam logic [7:0] ADDR_STATUS      = 8'h00;
	localparam logic [7:0] ADDR_FIFO_STATUS = 8'h00;
	localparam logic [7:0] ADDR_OUT_FIRST   = 8'h01;
	localparam logic [7:0] ADDR_OUT_LAST    = 8'h05;
	localparam logic [7:0] ADDR_INT_SOURCE  = 8'h12;
	localparam logic [7:0] ADDR_EVENT_CFG   = 8'h13;

	localparam logic [7:0] INT_SOURCE_RESET = 8'h00;
	localparam logic [2:0] EVENT_CFG_RESET  = 3'h0;
	localparam logic [7:0] EVENT_CFG_WMASK  = 8'h07;
	localparam int         CFG_WIDTH        = 3;

	localparam int BIT_DATA_READY  = 7;
	localparam int BIT_FIFO        = 6;
	localparam int BIT_PRESS_WIN   = 5;
	localparam int BIT_TEMP_WIN    = 4;
	localparam int BIT_PRESS_THR   = 3;
	localparam int BIT_TEMP_THR    = 2;
	localparam int BIT_PRESS_DELTA = 1;
	localparam int BIT_TEMP_DELTA  = 0;

	localparam int CFG_CHANGE_MODE = 2;
	localparam int CFG_PRESS_EN    = 1;
	localparam int CFG_TEMP_EN     = 0;

	localparam logic [5:0] FIFO_FULL_COUNT   = 6'h20;
	localparam logic [5:0] WATERMARK_OFF     = 6'h00;
	localparam int         NUM_SOURCES       = 8;
endpackage : sisc_pkg

// [design/sisc_edge_latch.sv]
// Purpose: Sticky status bit set by a rising edge of its event level
// Assumes: Event level and clear are synchronous to clock
// Notes:   A set in the clear cycle wins, so no event is lost
`timescale 1ns/10ps
module sisc_edge_latch (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst_n,
	// Event and clear
	input  wire logic event_level,
	input  wire logic clear,
	// Status
	output logic      flag_reg
);
	logic level_reg;
	logic flag_next;
	logic rise;

	always_comb begin
		rise      = event_level & ~level_reg;
		flag_next = rise | (flag_reg & ~clear);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			level_reg <= 1'b0;
			flag_reg  <= 1'b0;
		end else begin
			level_reg <= event_level;
			flag_reg  <= flag_next;
		end
	end

	set_on_rise_a: assert property (@(posedge clock) disable iff (!rst_n)
		(event_level && !$past(event_level)) |=> flag_reg)
		else $error("Flag not set after rising event");
	no_rise_set_a: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(flag_reg) |-> $past(event_level) && !$past(event_level, 2))
		else $error("Flag set without rising event");
	set_beats_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
		(clear && event_level && !$past(event_level)) |=> flag_reg)
		else $error("Event lost under clear");
endmodule : sisc_edge_latch

// [design/sisc_int_source.sv]
// Purpose: Interrupt source status and data event configuration registers
// Assumes: Register port strobes come from the serial interface core, one cycle each
// Notes:   Measurement values are compared unsigned except against the lower window edge, which is signed; sample strobes are one cycle
`timescale 1ns/10ps
module sisc_int_source (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_rd,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata_reg,
	// Data ready sources
	input  wire logic        new_data_flag,
	input  wire logic        data_overwrite_flag,
	input  wire logic        data_ready_enable,
	// FIFO sources
	input  wire logic        fifo_enabled,
	input  wire logic [5:0]  fifo_sample_count,
	input  wire logic [5:0]  fifo_watermark_level,
	// Pressure measurement
	input  wire logic        press_sample,
	input  wire logic [15:0] press_value,
	input  wire logic [15:0] press_target,
	input  wire logic [15:0] press_window,
	// Temperature measurement
	input  wire logic        temp_sample,
	input  wire logic [7:0]  temp_value,
	input  wire logic [7:0]  temp_target,
	input  wire logic [7:0]  temp_window,
	// Status and events
	output logic      [7:0]  int_source,
	output logic             fifo_overflow_flag_reg,
	output logic             press_data_event_reg,
	output logic             temp_data_event_reg
);
	// Configuration and readback state
	logic [2:0]  cfg_reg;
	logic [2:0]  cfg_next;
	logic [7:0]  rdata_next;
	logic        status_seen_reg;
	logic        status_seen_next;
	// Measurement history
	logic [15:0] press_prev_reg;
	logic [15:0] press_prev_next;
	logic [7:0]  temp_prev_reg;
	logic [7:0]  temp_prev_next;
	logic        press_win_reg;
	logic        press_win_next;
	logic        temp_win_reg;
	logic        temp_win_next;
	logic        press_cross_reg;
	logic        press_cross_next;
	logic        temp_cross_reg;
	logic        temp_cross_next;
	logic        press_evt_next;
	logic        temp_evt_next;
	logic        ovf_next;
	// Source decode
	logic [7:0]  src_level;
	logic [7:0]  src_clear;
	logic        read_status;
	logic        read_fifo;
	logic        read_output;
	logic        read_source;

	// Crossing of any of lower, center or upper; only center with zero window
	function automatic logic crossed(input logic [17:0] prev, input logic [17:0] cur,
			input logic [17:0] tgt, input logic [17:0] win);
		logic [17:0] hi;
		logic [17:0] lo;
		logic        c;
		hi = tgt + win;
		lo = tgt - win;
		c  = (prev < tgt) != (cur < tgt);
		if (win != 18'h0_0000) begin
			c = c | ((prev < hi) != (cur < hi));
			c = c | ($signed(prev) < $signed(lo)) != ($signed(cur) < $signed(lo));
		end
		crossed = c;
	endfunction : crossed

	// Inside target plus or minus window; zero window never matches
	function automatic logic in_window(input logic [17:0] cur, input logic [17:0] tgt,
			input logic [17:0] win);
		logic [17:0] diff;
		diff      = (cur >= tgt) ? cur - tgt : tgt - cur;
		in_window = (win != 18'h0_0000) && (diff <= win);
	endfunction : in_window

	always_comb begin
		read_status = reg_rd && (reg_addr == sisc_pkg::ADDR_STATUS) && !fifo_enabled;
		read_fifo   = reg_rd && (reg_addr == sisc_pkg::ADDR_FIFO_STATUS) && fifo_enabled;
		read_output = reg_rd && (reg_addr >= sisc_pkg::ADDR_OUT_FIRST)
			&& (reg_addr <= sisc_pkg::ADDR_OUT_LAST);
		read_source = reg_rd && (reg_addr == sisc_pkg::ADDR_INT_SOURCE);
	end

	// Register port: only the three low config bits are stored
	always_comb begin
		cfg_next         = cfg_reg;
		status_seen_next = status_seen_reg;
		rdata_next       = 8'h00;
		if (reg_wr && (reg_addr == sisc_pkg::ADDR_EVENT_CFG)) begin
			cfg_next = reg_wdata[sisc_pkg::CFG_WIDTH-1:0];
		end
		// A write to the source address falls through untouched
		if (read_status) begin
			status_seen_next = 1'b1;
		end else if (read_output) begin
			status_seen_next = 1'b0;
		end
		if (reg_rd) begin
			case (reg_addr)
				sisc_pkg::ADDR_INT_SOURCE: rdata_next = int_source;
				sisc_pkg::ADDR_EVENT_CFG:  rdata_next = {5'h00, cfg_reg};
				default:                   rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg         <= sisc_pkg::EVENT_CFG_RESET;
			status_seen_reg <= 1'b0;
			reg_rdata_reg   <= 8'h00;
		end else begin
			cfg_reg         <= cfg_next;
			status_seen_reg <= status_seen_next;
			reg_rdata_reg   <= rdata_next;
		end
	end

	// Measurement tracking, updated on each sample strobe; FIFO overflow flag updated every cycle
	always_comb begin
		press_prev_next  = press_prev_reg;
		temp_prev_next   = temp_prev_reg;
		press_win_next   = press_win_reg;
		temp_win_next    = temp_win_reg;
		press_cross_next = 1'b0;
		temp_cross_next  = 1'b0;
		press_evt_next   = 1'b0;
		temp_evt_next    = 1'b0;
		if (press_sample) begin
			press_prev_next  = press_value;
			press_win_next   = in_window({2'b00, press_value}, {2'b00, press_target},
				{2'b00, press_window});
			press_cross_next = crossed({2'b00, press_prev_reg}, {2'b00, press_value},
				{2'b00, press_target}, {2'b00, press_window});
			press_evt_next   = cfg_reg[sisc_pkg::CFG_PRESS_EN]
				&& (!cfg_reg[sisc_pkg::CFG_CHANGE_MODE]
				|| (press_value != press_prev_reg));
		end
		if (temp_sample) begin
			temp_prev_next  = temp_value;
			temp_win_next   = in_window({10'h000, temp_value}, {10'h000, temp_target},
				{10'h000, temp_window});
			temp_cross_next = crossed({10'h000, temp_prev_reg}, {10'h000, temp_value},
				{10'h000, temp_target}, {10'h000, temp_window});
			temp_evt_next   = cfg_reg[sisc_pkg::CFG_TEMP_EN]
				&& (!cfg_reg[sisc_pkg::CFG_CHANGE_MODE]
				|| (temp_value != temp_prev_reg));
		end
		ovf_next = fifo_enabled && (fifo_sample_count == sisc_pkg::FIFO_FULL_COUNT);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			press_prev_reg         <= 16'h0000;
			temp_prev_reg          <= 8'h00;
			press_win_reg          <= 1'b0;
			temp_win_reg           <= 1'b0;
			press_cross_reg        <= 1'b0;
			temp_cross_reg         <= 1'b0;
			press_data_event_reg   <= 1'b0;
			temp_data_event_reg    <= 1'b0;
			fifo_overflow_flag_reg <= 1'b0;
		end else begin
			press_prev_reg         <= press_prev_next;
			temp_prev_reg          <= temp_prev_next;
			press_win_reg          <= press_win_next;
			temp_win_reg           <= temp_win_next;
			press_cross_reg        <= press_cross_next;
			temp_cross_reg         <= temp_cross_next;
			press_data_event_reg   <= press_evt_next;
			temp_data_event_reg    <= temp_evt_next;
			fifo_overflow_flag_reg <= ovf_next;
		end
	end

	// Source levels and their clearing reads
	always_comb begin
		src_level = 8'h00;
		src_clear = 8'h00;
		src_level[sisc_pkg::BIT_DATA_READY]  = (new_data_flag | data_overwrite_flag)
			& data_ready_enable;
		src_level[sisc_pkg::BIT_FIFO]        = fifo_overflow_flag_reg
			| (fifo_enabled && (fifo_watermark_level != sisc_pkg::WATERMARK_OFF)
			&& (fifo_sample_count == fifo_watermark_level));
		src_level[sisc_pkg::BIT_PRESS_WIN]   = press_win_reg;
		src_level[sisc_pkg::BIT_TEMP_WIN]    = temp_win_reg;
		src_level[sisc_pkg::BIT_PRESS_THR]   = press_cross_reg;
		src_level[sisc_pkg::BIT_TEMP_THR]    = temp_cross_reg;
		src_level[sisc_pkg::BIT_PRESS_DELTA] = press_data_event_reg;
		src_level[sisc_pkg::BIT_TEMP_DELTA]  = temp_data_event_reg;
		src_clear[sisc_pkg::BIT_DATA_READY]  = read_output && status_seen_reg;
		src_clear[sisc_pkg::BIT_FIFO]        = read_fifo;
		src_clear[5:0]                       = {6{read_source}};
	end

	// Status bits only move through set and clear, never by a write
	genvar gi;
	generate
		for (gi = 0; gi < sisc_pkg::NUM_SOURCES; gi++) begin : g_src
			sisc_edge_latch u_latch (
				.clock       (clock),
				.rst_n       (rst_n),
				.event_level (src_level[gi]),
				.clear       (src_clear[gi]),
				.flag_reg    (int_source[gi])
			);
		end
	endgenerate

	drdy_needs_seq_a: assert property (@(posedge clock) disable iff (!rst_n)
		$fell(int_source[sisc_pkg::BIT_DATA_READY]) |-> $past(read_output && status_seen_reg))
		else $error("Data ready cleared without status then output read");
	fifo_clear_read_a: assert property (@(posedge clock) disable iff (!rst_n)
		$fell(int_source[sisc_pkg::BIT_FIFO]) |-> $past(read_fifo))
		else $error("FIFO bit cleared without FIFO status read");
	write_ignored_a: assert property (@(posedge clock) disable iff (!rst_n)
		(reg_wr && !reg_rd && reg_addr == sisc_pkg::ADDR_INT_SOURCE
		&& src_level == 8'h00) |=> (int_source & ~$past(int_source)) == 8'h00)
		else $error("Write changed status bits");
	zero_win_press_a: assert property (@(posedge clock) disable iff (!rst_n)
		(press_sample && press_window == 16'h0000) |=> !press_win_reg)
		else $error("Pressure window alert with zero window");
	zero_win_temp_a: assert property (@(posedge clock) disable iff (!rst_n)
		(temp_sample && temp_window == 8'h00) |=> !temp_win_reg)
		else $error("Temperature window alert with zero window");
	center_cross_a: assert property (@(posedge clock) disable iff (!rst_n)
		(press_sample && (press_prev_reg < press_target) && (press_value >= press_target))
		|=> press_cross_reg ##1 int_source[sisc_pkg::BIT_PRESS_THR])
		else $error("Center crossing not flagged");
	every_sample_a: assert property (@(posedge clock) disable iff (!rst_n)
		(temp_sample && cfg_reg == 3'h1) |=> temp_data_event_reg)
		else $error("Temperature data event missed in every-sample mode");
	change_only_a: assert property (@(posedge clock) disable iff (!rst_n)
		(press_sample && cfg_reg[sisc_pkg::CFG_CHANGE_MODE]
		&& press_value == press_prev_reg) |=> !press_data_event_reg)
		else $error("Pressure event without data change");
	press_disable_a: assert property (@(posedge clock) disable iff (!rst_n)
		!cfg_reg[sisc_pkg::CFG_PRESS_EN] |=> !press_data_event_reg)
		else $error("Pressure event while disabled");
	wmrk_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
		(fifo_watermark_level == sisc_pkg::WATERMARK_OFF && !fifo_overflow_flag_reg)
		|-> !src_level[sisc_pkg::BIT_FIFO])
		else $error("FIFO event with zero watermark and no overflow");
	overflow_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
		(fifo_enabled && fifo_sample_count == 6'h20) |=> fifo_overflow_flag_reg)
		else $error("Overflow not flagged at full count");
	cfg_readback_a: assert property (@(posedge clock) disable iff (!rst_n)
		(reg_rd && reg_addr == sisc_pkg::ADDR_EVENT_CFG) |=> reg_rdata_reg[7:3] == 5'h00)
		else $error("Reserved config bits read nonzero");
	drdy_rise_set_a: assert property (@(posedge clock) disable iff (!rst_n)
		$rose((new_data_flag || data_overwrite_flag) && data_ready_enable)
		|=> int_source[sisc_pkg::BIT_DATA_READY])
		else $error("Data ready bit not set on new data");
	fifo_mark_set_a: assert property (@(posedge clock) disable iff (!rst_n)
		($rose(fifo_enabled && (fifo_watermark_level != sisc_pkg::WATERMARK_OFF)
		&& (fifo_sample_count == fifo_watermark_level)) && !$past(fifo_overflow_flag_reg))
		|=> int_source[sisc_pkg::BIT_FIFO])
		else $error("FIFO bit not set on watermark match");
	temp_center_a: assert property (@(posedge clock) disable iff (!rst_n)
		(temp_sample && (temp_prev_reg >= temp_target) && (temp_value < temp_target))
		|=> temp_cross_reg)
		else $error("Temperature center crossing not flagged");
	press_delta_a: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(press_data_event_reg) |=> int_source[sisc_pkg::BIT_PRESS_DELTA])
		else $error("Pressure delta bit not set on data event");
	temp_disable_a: assert property (@(posedge clock) disable iff (!rst_n)
		!cfg_reg[sisc_pkg::CFG_TEMP_EN] |=> !temp_data_event_reg)
		else $error("Temperature event while disabled");
	source_read_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
		(read_source && src_level[5:0] == 6'h00) |=> int_source[5:0] == 6'h00)
		else $error("Source read did not clear status bits");
endmodule : sisc_int_source

// [test/sisc_host_model.sv]
// Purpose: Host side model driving the register strobes of the status block
// Assumes: Strobes change at the falling edge and last one cycle
// Notes:   Released address and data show the inverse of the last value
`timescale 1ns/10ps
module sisc_host_model (
	// Clock
	input  wire logic       clock,
	// Register port
	output logic      [7:0] reg_addr,
	output logic            reg_rd,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata_reg
);
	initial begin
		reg_addr  = 8'h00;
		reg_rd    = 1'b0;
		reg_wr    = 1'b0;
		reg_wdata = 8'h00;
	end

	// Read data is taken at the falling edge after the read edge
	task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wd,
		output logic [7:0] rd);
		@(negedge clock);
		reg_addr  = addr;
		reg_wdata = wd;
		reg_rd    = ~wr;
		reg_wr    = wr;
		@(negedge clock);
		reg_rd    = 1'b0;
		reg_wr    = 1'b0;
		// A stale bus would hide a decoder that ignores the strobe
		reg_addr  = ~addr;
		reg_wdata = ~wd;
		rd        = reg_rdata_reg;
	endtask : access
endmodule : sisc_host_model

// [test/sisc_int_source_tb.sv]
// Purpose: Self-checking bench for the interrupt source and event config block
// Assumes: Register traffic goes through the host model
// Notes:   Status bits are checked under masks where other sources may also fire
`timescale 1ns/10ps
module sisc_int_source_tb;
	logic        clock;
	logic        rst_n;
	logic [7:0]  reg_addr;
	logic        reg_rd;
	logic        reg_wr;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata_reg;
	logic        new_data_flag;
	logic        data_overwrite_flag;
	logic        data_ready_enable;
	logic        fifo_enabled;
	logic [5:0]  fifo_sample_count;
	logic [5:0]  fifo_watermark_level;
	logic        press_sample;
	logic [15:0] press_value;
	logic [15:0] press_target;
	logic [15:0] press_window;
	logic        temp_sample;
	logic [7:0]  temp_value;
	logic [7:0]  temp_target;
	logic [7:0]  temp_window;
	logic [7:0]  int_source;
	logic        fifo_overflow_flag_reg;
	logic        press_data_event_reg;
	logic        temp_data_event_reg;
	logic [1:0]  ev_pulse;
	logic [7:0]  rd;
	int          fails;
	int          n_tests;
	logic [7:0]  ev_cfg [6] = '{8'h02, 8'h06, 8'h06, 8'h04, 8'h01, 8'h04};
	logic        ev_tp  [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
	logic [15:0] ev_val [6] = '{16'h0406, 16'h0406, 16'h0410, 16'h0420, 16'h0028, 16'h0030};
	logic [7:0]  ev_exp [6] = '{8'h02, 8'h00, 8'h02, 8'h00, 8'h01, 8'h00};

	sisc_int_source uut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_reg(reg_rdata_reg),
		.new_data_flag(new_data_flag), .data_overwrite_flag(data_overwrite_flag),
		.data_ready_enable(data_ready_enable), .fifo_enabled(fifo_enabled),
		.fifo_sample_count(fifo_sample_count), .fifo_watermark_level(fifo_watermark_level),
		.press_sample(press_sample), .press_value(press_value), .press_target(press_target),
		.press_window(press_window), .temp_sample(temp_sample), .temp_value(temp_value),
		.temp_target(temp_target), .temp_window(temp_window), .int_source(int_source),
		.fifo_overflow_flag_reg(fifo_overflow_flag_reg),
		.press_data_event_reg(press_data_event_reg),
		.temp_data_event_reg(temp_data_event_reg));

	sisc_host_model host (.clock(clock), .reg_addr(reg_addr), .reg_rd(reg_rd),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_reg(reg_rdata_reg));

	initial clock = 1'b0;
	always #25 clock = ~clock;

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.access(1'b1, a, d, rd);
	endtask : wr

	task automatic rdx(input logic [7:0] a);
		host.access(1'b0, a, 8'h00, rd);
	endtask : rdx

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
		rdx(a);
		check(name, exp, rd);
	endtask : rd_chk

	task automatic waitn(input int n);
		repeat (n) @(negedge clock);
	endtask : waitn

	// One sample pulse, then time for the status bit to land
	task automatic samp(input logic tp, input logic [15:0] v);
		@(negedge clock);
		if (tp) begin
			press_value  = v;
			press_sample = 1'b1;
		end else begin
			temp_value  = v[7:0];
			temp_sample = 1'b1;
		end
		@(negedge clock);
		// Event pulses stand for this one cycle only
		ev_pulse     = {press_data_event_reg, temp_data_event_reg};
		press_sample = 1'b0;
		temp_sample  = 1'b0;
		waitn(2);
	endtask : samp

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (4000) @(posedge clock);
		fails++;
		complete_run();
	end

	initial begin
		rst_n = 1'b0;
		{new_data_flag, data_overwrite_flag, data_ready_enable, fifo_enabled} = 4'h0;
		{fifo_sample_count, fifo_watermark_level} = 12'h000;
		{press_sample, temp_sample, press_value, press_window, temp_value, temp_window} = '0;
		press_target = 16'h03e8;
		temp_target  = 8'h32;
		repeat (6) @(posedge clock);
		@(negedge clock);
		rst_n = 1'b1;
		rd_chk("status reset", 8'h12, 8'h00);
		rd_chk("config reset", 8'h13, 8'h00);
		wr(8'h13, 8'hff);
		rd_chk("config mask", 8'h13, 8'h07);
		wr(8'h12, 8'hff);
		rd_chk("status write", 8'h12, 8'h00);
		rd_chk("unmapped", 8'h40, 8'h00);
		new_data_flag = 1'b1;
		waitn(3);
		check("ready disabled", 8'h00, int_source);
		new_data_flag = 1'b0;
		data_ready_enable = 1'b1;
		waitn(2);
		new_data_flag = 1'b1;
		waitn(3);
		rd_chk("ready read", 8'h12, 8'h80);
		rdx(8'h00);
		check("ready armed", 8'h80, int_source);
		rdx(8'h03);
		check("ready cleared", 8'h00, int_source);
		new_data_flag = 1'b0;
		waitn(2);
		data_overwrite_flag = 1'b1;
		waitn(3);
		check("overwrite", 8'h80, int_source);
		rdx(8'h05);
		check("ready needs status", 8'h80, int_source);
		rdx(8'h00);
		rdx(8'h05);
		check("overwrite cleared", 8'h00, int_source);
		fifo_enabled = 1'b1;
		waitn(3);
		check("watermark off", 8'h00, int_source);
		fifo_watermark_level = 6'h05;
		fifo_sample_count = 6'h04;
		waitn(3);
		check("below mark", 8'h00, int_source);
		fifo_sample_count = 6'h05;
		waitn(3);
		rdx(8'h12);
		check("fifo kept", 8'h40, int_source);
		rdx(8'h00);
		check("fifo cleared", 8'h00, int_source);
		fifo_sample_count = 6'h1f;
		waitn(2);
		check("no overflow", 8'h00, {7'h00, fifo_overflow_flag_reg});
		fifo_sample_count = 6'h20;
		waitn(1);
		check("overflow flag", 8'h01, {7'h00, fifo_overflow_flag_reg});
		waitn(2);
		check("overflow bit", 8'h40, int_source);
		rdx(8'h00);
		fifo_enabled = 1'b0;
		samp(1'b1, 16'h0384);
		check("below center", 8'h00, int_source & 8'h28);
		samp(1'b1, 16'h044c);
		check("center cross", 8'h08, int_source & 8'h28);
		samp(1'b1, 16'h03e8);
		check("zero window", 8'h00, int_source & 8'h20);
		press_window = 16'h0014;
		rdx(8'h12);
		samp(1'b1, 16'h03f2);
		check("in window", 8'h20, int_source & 8'h20);
		rdx(8'h12);
		samp(1'b1, 16'h0406);
		check("upper cross", 8'h08, int_source & 8'h28);
		samp(1'b0, 16'h0028);
		check("temp below", 8'h00, int_source & 8'h14);
		samp(1'b0, 16'h003c);
		check("temp center", 8'h04, int_source & 8'h14);
		samp(1'b0, 16'h0032);
		check("temp zero win", 8'h00, int_source & 8'h10);
		temp_window = 8'h05;
		rdx(8'h12);
		samp(1'b0, 16'h0034);
		check("temp in window", 8'h10, int_source & 8'h10);
		rdx(8'h12);
		samp(1'b0, 16'h0028);
		check("temp lower", 8'h04, int_source & 8'h14);
		for (int i = 0; i < 6; i++) begin
			wr(8'h13, ev_cfg[i]);
			rdx(8'h12);
			samp(ev_tp[i], ev_val[i]);
			check("data event", ev_exp[i], int_source & 8'h03);
			check("event pulse", ev_exp[i], {6'h00, ev_pulse});
			ev_pulse = {press_data_event_reg, temp_data_event_reg};
			check("pulse ends", 8'h00, {6'h00, ev_pulse});
		end
		wr(8'h13, 8'h02);
		rdx(8'h12);
		@(negedge clock);
		press_sample = 1'b1;
		fork
			rdx(8'h12);
			begin
				@(negedge clock);
				press_sample = 1'b0;
			end
		join
		waitn(2);
		check("set over clear", 8'h02, int_source & 8'h02);
		complete_run();
	end
endmodule : sisc_int_source_tb
